// ### core/rfs_top.v
`timescale 1ns/1ps
`include "rfs_consts.vh"

// Function
// - Interleave bus runs only while the interleave enable bit is one.
// - Three-bit position field picks slot one through eight on the interleave bus.
// - T1 spare code length: codes 0-6 mean 1-7 bits, 7 means 8/16.
// - Test port fed from receive framer at zero, transmit path at one.
// - T1 unframed bit clocks the framing-bit position into the checker.
// - Test port active only while its enable bit is one.
// - Suppress bits drop matching channel bits, bit 7 is channel MSB.
// - All alarm flags latch and may raise an interrupt.
// - Low nibble latches rising edges, high nibble falling edges of four alarms.
// - Loss of signal asserts after 192 consecutive received zeros.
// - AIS, remote alarm and loss of frame follow their received conditions.
// - T1 framing-event flags latch but never request an interrupt.
// - T1 flags latch on zero runs of eight and of sixteen or more.
// - T1 severe framing flag latches on two errors in six framing bits.
// - T1 flag latches on every B8ZS codeword, decoding enabled or not.
// - T1 frame bit error flag latches on every errored framing bit.
// - T1 flag latches when a resync changed frame or multiframe alignment.
// - E1 bits 0-3 may request interrupts, resync flags 4-6 may not.
// - E1 CRC resync flag latches at 915 errored of 1000 codewords.
// - E1 flags on three errored FAS words, two errored CAS words.
// - E1 slot 16 under-three-zeros and all-zeros flags over 16 frames.
// - E1 multiframe flag on CRC-4 boundary or 2ms, align flag every 250us.
module rfs_top #(
	parameter MF_CYCLES = (`RFS_MF_TIME_MS * 1000000) / `RFS_CLK_PERIOD_NS,
	parameter ALIGN_CYCLES = (`RFS_ALIGN_TIME_US * 1000) / `RFS_CLK_PERIOD_NS
) (
	input wire clk_sys,
	input wire reset,
	input wire e1_mode,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire line_valid,
	input wire line_bit,
	input wire remote_alarm_cond,
	input wire all_ones_alarm_cond,
	input wire frame_loss_cond,
	input wire pulse_density_violation,
	input wire b8zs_codeword,
	input wire resync_align_changed,
	input wire fbit_strobe,
	input wire fbit_error,
	input wire fas_strobe,
	input wire fas_error,
	input wire cas_strobe,
	input wire cas_error,
	input wire crc_strobe,
	input wire crc_error,
	input wire crc4_enable,
	input wire crc_mf_boundary,
	input wire ts16_strobe,
	input wire ts16_mf_start,
	input wire [7:0] ts16_byte,
	input wire rx_data_valid,
	input wire rx_data,
	input wire tx_data_valid,
	input wire tx_data,
	input wire [2:0] chan_bit_index,
	input wire chan_fbit,
	output wire interleave_enable,
	output wire [2:0] bus_device_position,
	output wire [2:0] spare_code_length,
	output reg [3:0] spare_code_bits,
	output reg spare_code_long,
	output reg test_port_data,
	output reg test_port_clk_en,
	output wire signal_loss_cond,
	output wire alarm_event_pending,
	output wire framing_event_pending
);

	// ==========================================
	// Control registers
	reg [7:0] interleave_bus_ctrl;
	reg [7:0] spare_code_length_ctrl;
	reg [7:0] test_port_ctrl;
	reg [7:0] test_port_bit_suppress;
	wire [7:0] alarm_latched_status;
	wire [7:0] framing_event_latched_status;

	always @(posedge clk_sys) begin
		if (reset) begin
			interleave_bus_ctrl <= `RFS_RESET_BYTE;
			spare_code_length_ctrl <= `RFS_RESET_BYTE;
			test_port_ctrl <= `RFS_RESET_BYTE;
			test_port_bit_suppress <= `RFS_RESET_BYTE;
		end else if (reg_wr) begin
			case (reg_addr)
				`RFS_ADDR_IBUS_CTRL: interleave_bus_ctrl <= reg_wdata & 8'h7F;
				`RFS_ADDR_SPARE_CTRL: spare_code_length_ctrl <= reg_wdata & 8'h07;
				`RFS_ADDR_PORT_CTRL: test_port_ctrl <= reg_wdata & 8'h07;
				`RFS_ADDR_SUPPRESS: test_port_bit_suppress <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge clk_sys) begin
		if (reset)
			reg_rdata <= 8'h00;
		else if (reg_rd) begin
			case (reg_addr)
				`RFS_ADDR_IBUS_CTRL: reg_rdata <= interleave_bus_ctrl;
				`RFS_ADDR_SPARE_CTRL: reg_rdata <= spare_code_length_ctrl;
				`RFS_ADDR_PORT_CTRL: reg_rdata <= test_port_ctrl;
				`RFS_ADDR_SUPPRESS: reg_rdata <= test_port_bit_suppress;
				`RFS_ADDR_ALARM_STAT: reg_rdata <= alarm_latched_status;
				`RFS_ADDR_FRAME_STAT: reg_rdata <= framing_event_latched_status;
				default: reg_rdata <= 8'h00;
			endcase
		end else
			reg_rdata <= 8'h00;
	end

	wire clr_alarm = reg_wr && (reg_addr == `RFS_ADDR_ALARM_STAT);
	wire clr_frame = reg_wr && (reg_addr == `RFS_ADDR_FRAME_STAT);

	// ==========================================
	// Interleave bus and spare code decode
	assign interleave_enable = interleave_bus_ctrl[`RFS_IBUS_EN_BIT];
	assign bus_device_position = interleave_bus_ctrl[`RFS_IBUS_POS_MSB:0];
	assign spare_code_length = spare_code_length_ctrl[`RFS_SPARE_LEN_MSB:0];

	// Spare code only has meaning in T1; E1 reports a zero length
	always @(posedge clk_sys) begin
		if (reset) begin
			spare_code_bits <= 4'h0;
			spare_code_long <= 1'b0;
		end else if (e1_mode) begin
			spare_code_bits <= 4'h0;
			spare_code_long <= 1'b0;
		end else begin
			spare_code_long <= &spare_code_length;
			spare_code_bits <= {1'b0, spare_code_length} + 4'h1;
		end
	end

	// ==========================================
	// Receive test-pattern port
	wire port_dir = test_port_ctrl[`RFS_PORT_DIR_BIT];
	wire port_unframed = test_port_ctrl[`RFS_PORT_UNFR_BIT] & ~e1_mode;
	wire port_en = test_port_ctrl[`RFS_PORT_EN_BIT];
	wire src_valid = port_dir ? tx_data_valid : rx_data_valid;
	wire src_data = port_dir ? tx_data : rx_data;
	wire fbit_blocked = chan_fbit & ~port_unframed;
	wire bit_blocked = ~chan_fbit & test_port_bit_suppress[chan_bit_index];

	always @(posedge clk_sys) begin
		if (reset) begin
			test_port_data <= 1'b0;
			test_port_clk_en <= 1'b0;
		end else begin
			test_port_clk_en <= port_en & src_valid & ~fbit_blocked & ~bit_blocked;
			if (port_en && src_valid)
				test_port_data <= src_data;
		end
	end

	// ==========================================
	// Line zero runs
	wire [7:0] zero_run;

	rfs_run_cnt #(
		.WIDTH(8),
		.MAX(8'hFF)
	) u_zero_run (
		.clk_sys(clk_sys),
		.reset(reset),
		.strobe(line_valid),
		.hit(~line_bit),
		.count(zero_run)
	);

	assign signal_loss_cond = (zero_run >= `RFS_LOS_ZEROS);
	wire zero_step = line_valid & ~line_bit;
	wire z8_hit = zero_step & (zero_run == `RFS_Z8_LEN - 8'h01);
	wire z16_hit = zero_step & (zero_run == `RFS_Z16_LEN - 8'h01);

	// ==========================================
	// Alarm edges
	wire [3:0] cond_now = {remote_alarm_cond, all_ones_alarm_cond, signal_loss_cond,
		frame_loss_cond};
	reg [3:0] cond_prev;

	always @(posedge clk_sys) begin
		if (reset)
			cond_prev <= 4'h0;
		else
			cond_prev <= cond_now;
	end

	wire [7:0] alarm_set = {cond_prev & ~cond_now, cond_now & ~cond_prev};

	rfs_flag_bank #(
		.WIDTH(8)
	) u_alarm_flags (
		.clk_sys(clk_sys),
		.reset(reset),
		.set(alarm_set),
		.clr(clr_alarm ? reg_wdata : 8'h00),
		.flags(alarm_latched_status)
	);

	assign alarm_event_pending = |alarm_latched_status;

	// ==========================================
	// T1 framing bit checks
	reg [5:0] fbit_hist;
	wire [5:0] fbit_next = {fbit_hist[4:0], fbit_error};
	reg [2:0] fbit_errs;
	integer k;

	always @* begin
		fbit_errs = 3'h0;
		for (k = 0; k < 6; k = k + 1)
			fbit_errs = fbit_errs + {2'b00, fbit_next[k]};
	end

	always @(posedge clk_sys) begin
		if (reset)
			fbit_hist <= 6'h00;
		else if (fbit_strobe)
			fbit_hist <= fbit_next;
	end

	wire severe_framing_error_flag_hit = fbit_strobe & fbit_error & (fbit_errs >= 3'h2);
	wire fbe_hit = fbit_strobe & fbit_error;

	// ==========================================
	// E1 resync criteria
	wire [1:0] fas_run;
	wire [1:0] cas_run;

	rfs_run_cnt #(
		.WIDTH(2),
		.MAX(2'h3)
	) u_fas_run (
		.clk_sys(clk_sys),
		.reset(reset),
		.strobe(fas_strobe),
		.hit(fas_error),
		.count(fas_run)
	);

	rfs_run_cnt #(
		.WIDTH(2),
		.MAX(2'h3)
	) u_cas_run (
		.clk_sys(clk_sys),
		.reset(reset),
		.strobe(cas_strobe),
		.hit(cas_error),
		.count(cas_run)
	);

	wire fas_hit = fas_strobe & fas_error & (fas_run == `RFS_FAS_ERR_RUN - 2'h1);
	wire cas_hit = cas_strobe & cas_error & (cas_run == `RFS_CAS_ERR_RUN - 2'h1);

	// Fixed 1000-word windows; the flag fires once when errors reach 915
	reg [9:0] crc_words;
	reg [9:0] crc_errs;
	wire crc_hit = crc_strobe & crc_error & (crc_errs == `RFS_CRC_ERR_LIMIT - 10'h001);

	always @(posedge clk_sys) begin
		if (reset) begin
			crc_words <= 10'h000;
			crc_errs <= 10'h000;
		end else if (crc_strobe) begin
			if (crc_words == `RFS_CRC_WINDOW - 10'h001) begin
				crc_words <= 10'h000;
				crc_errs <= 10'h000;
			end else begin
				crc_words <= crc_words + 10'h001;
				crc_errs <= crc_errs + {9'h000, crc_error};
			end
		end
	end

	// ==========================================
	// E1 slot 16 content over 16 frames
	reg [3:0] ts16_frame;
	reg [1:0] ts16_zeros;
	reg ts16_any_one;
	reg [3:0] byte_zeros;
	reg [2:0] sum_zeros;
	integer j;

	always @* begin
		byte_zeros = 4'h0;
		for (j = 0; j < 8; j = j + 1)
			byte_zeros = byte_zeros + {3'h0, ~ts16_byte[j]};
		sum_zeros = {1'b0, ts16_zeros} + ((byte_zeros > 4'h3) ? 3'h3 : byte_zeros[2:0]);
	end

	wire ts16_first = ts16_mf_start | (ts16_frame == 4'h0);
	wire [2:0] acc_zeros = ts16_first ? sum_zeros - {1'b0, ts16_zeros} : sum_zeros;
	wire acc_one = (ts16_first ? 1'b0 : ts16_any_one) | (|ts16_byte);
	wire ts16_last = ts16_strobe & ~ts16_mf_start & (ts16_frame == `RFS_TS16_FRAMES);
	wire sa1_hit = ts16_last & (acc_zeros < {1'b0, `RFS_TS16_MIN_ZEROS});
	wire sa0_hit = ts16_last & ~acc_one;

	always @(posedge clk_sys) begin
		if (reset) begin
			ts16_frame <= 4'h0;
			ts16_zeros <= 2'h0;
			ts16_any_one <= 1'b0;
		end else if (ts16_strobe) begin
			ts16_frame <= ts16_mf_start ? 4'h1 : ts16_frame + 4'h1;
			ts16_zeros <= (acc_zeros > 3'h3) ? 2'h3 : acc_zeros[1:0];
			ts16_any_one <= acc_one;
		end
	end

	// ==========================================
	// E1 multiframe and align-frame timers
	reg [31:0] mf_timer;
	reg [31:0] align_timer;
	wire mf_tick = (mf_timer == MF_CYCLES - 1);
	wire align_tick = (align_timer == ALIGN_CYCLES - 1);

	always @(posedge clk_sys) begin
		if (reset) begin
			mf_timer <= 32'h00000000;
			align_timer <= 32'h00000000;
		end else begin
			mf_timer <= (mf_tick || crc4_enable) ? 32'h00000000 : mf_timer + 32'h00000001;
			align_timer <= align_tick ? 32'h00000000 : align_timer + 32'h00000001;
		end
	end

	// Without CRC-4 the boundary is arbitrary, so a free timer stands in
	wire cmf_hit = crc4_enable ? crc_mf_boundary : mf_tick;

	// ==========================================
	// Framing event flags, meaning set by line mode
	reg [7:0] frame_set;

	always @* begin
		frame_set = 8'h00;
		if (e1_mode) begin
			frame_set[`RFS_E1_CRC_RESYNC_FLAG_BIT] = crc_hit;
			frame_set[`RFS_E1_CAS_RESYNC_FLAG_BIT] = cas_hit;
			frame_set[`RFS_E1_FAS_RESYNC_FLAG_BIT] = fas_hit;
			frame_set[`RFS_E1_SA1_BIT] = sa1_hit;
			frame_set[`RFS_E1_SA0_BIT] = sa0_hit;
			frame_set[`RFS_E1_CMF_BIT] = cmf_hit;
			frame_set[`RFS_E1_RAF_BIT] = align_tick;
		end else begin
			frame_set[`RFS_T1_PDV_BIT] = pulse_density_violation;
			frame_set[`RFS_T1_ALIGNMENT_CHANGE_FLAG_BIT] = resync_align_changed;
			frame_set[`RFS_T1_Z8_BIT] = z8_hit;
			frame_set[`RFS_T1_Z16_BIT] = z16_hit;
			frame_set[`RFS_T1_SEVERE_FRAMING_ERROR_FLAG_BIT] = severe_framing_error_flag_hit;
			frame_set[`RFS_T1_B8ZS_BIT] = b8zs_codeword;
			frame_set[`RFS_T1_FBE_BIT] = fbe_hit;
		end
	end

	rfs_flag_bank #(
		.WIDTH(8)
	) u_frame_flags (
		.clk_sys(clk_sys),
		.reset(reset),
		.set(frame_set),
		.clr(clr_frame ? reg_wdata : 8'h00),
		.flags(framing_event_latched_status)
	);

	// T1 never requests; E1 only from the low nibble
	assign framing_event_pending = e1_mode &
		(|(framing_event_latched_status & `RFS_E1_IRQ_MASK));

endmodule // rfs_top

// ### core/rfs_consts.vh
`ifndef RFS_CONSTS_VH
`define RFS_CONSTS_VH

// ==========================================
// Register offsets
`define RFS_ADDR_IBUS_CTRL 8'h88
`define RFS_ADDR_SPARE_CTRL 8'h89
`define RFS_ADDR_PORT_CTRL 8'h8A
`define RFS_ADDR_SUPPRESS 8'h8B
`define RFS_ADDR_ALARM_STAT 8'h90
`define RFS_ADDR_FRAME_STAT 8'h91
`define RFS_ADDR_CODE_STAT 8'h92

// ==========================================
// Field positions
`define RFS_IBUS_EN_BIT 3
`define RFS_IBUS_POS_MSB 2
`define RFS_SPARE_LEN_MSB 2
`define RFS_PORT_DIR_BIT 2
`define RFS_PORT_UNFR_BIT 1
`define RFS_PORT_EN_BIT 0
`define RFS_T1_PDV_BIT 7
`define RFS_T1_ALIGNMENT_CHANGE_FLAG_BIT 5
`define RFS_T1_Z8_BIT 4
`define RFS_T1_Z16_BIT 3
`define RFS_T1_SEVERE_FRAMING_ERROR_FLAG_BIT 2
`define RFS_T1_B8ZS_BIT 1
`define RFS_T1_FBE_BIT 0
`define RFS_E1_CRC_RESYNC_FLAG_BIT 6
`define RFS_E1_CAS_RESYNC_FLAG_BIT 5
`define RFS_E1_FAS_RESYNC_FLAG_BIT 4
`define RFS_E1_SA1_BIT 3
`define RFS_E1_SA0_BIT 2
`define RFS_E1_CMF_BIT 1
`define RFS_E1_RAF_BIT 0
`define RFS_E1_IRQ_MASK 8'h0F

// ==========================================
// Reset values
`define RFS_RESET_BYTE 8'h00

// ==========================================
// Detection thresholds and timing
`define RFS_LOS_ZEROS 8'hC0
`define RFS_Z8_LEN 8'h08
`define RFS_Z16_LEN 8'h10
`define RFS_FAS_ERR_RUN 2'h3
`define RFS_CAS_ERR_RUN 2'h2
`define RFS_CRC_WINDOW 10'h3E8
`define RFS_CRC_ERR_LIMIT 10'h393
`define RFS_TS16_FRAMES 4'hF
`define RFS_TS16_MIN_ZEROS 2'h3
`define RFS_CLK_PERIOD_NS 10
`define RFS_MF_TIME_MS 2
`define RFS_ALIGN_TIME_US 250

`endif

// ### core/rfs_flag_bank.v
`timescale 1ns/1ps

// ==========================================
// Sticky flags, write-one-to-clear, set beats clear
module rfs_flag_bank #(
	parameter WIDTH = 8
) (
	input wire clk_sys,
	input wire reset,
	input wire [WIDTH-1:0] set,
	input wire [WIDTH-1:0] clr,
	output reg [WIDTH-1:0] flags
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
			always @(posedge clk_sys) begin
				if (reset)
					flags[i] <= 1'b0;
				else if (set[i])
					flags[i] <= 1'b1;
				else if (clr[i])
					flags[i] <= 1'b0;
			end
		end
	endgenerate

endmodule // rfs_flag_bank

// ### core/rfs_run_cnt.v
`timescale 1ns/1ps

// ==========================================
// Consecutive-hit run counter, saturating at MAX
module rfs_run_cnt #(
	parameter WIDTH = 8,
	parameter [WIDTH-1:0] MAX = {WIDTH{1'b1}}
) (
	input wire clk_sys,
	input wire reset,
	input wire strobe,
	input wire hit,
	output reg [WIDTH-1:0] count
);

	always @(posedge clk_sys) begin
		if (reset)
			count <= {WIDTH{1'b0}};
		else if (strobe) begin
			if (!hit)
				count <= {WIDTH{1'b0}};
			else if (count != MAX)
				count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

endmodule // rfs_run_cnt

// ### test/rfs_assertions.sv
`timescale 1ns/1ps
module rfs_assertions (
	input wire clk_sys,
	input wire reset,
	input wire e1_mode,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire line_valid,
	input wire line_bit,
	input wire remote_alarm_cond,
	input wire rx_data_valid,
	input wire rx_data,
	input wire [2:0] chan_bit_index,
	input wire chan_fbit,
	input wire [2:0] spare_code_length,
	input wire [3:0] spare_code_bits,
	input wire test_port_data,
	input wire test_port_clk_en,
	input wire signal_loss_cond,
	input wire alarm_event_pending,
	input wire framing_event_pending
);
	// ==========================================
	// Shadows of port setup and the zero run, kept from bus and line traffic only
	logic [2:0] pc;
	logic [7:0] sup;
	logic [7:0] zrun;
	wire rx_ok = rx_data_valid && !chan_fbit && !sup[chan_bit_index];
	always @(posedge clk_sys) begin
		if (reset) begin
			pc <= 3'h0;
			sup <= 8'h00;
			zrun <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == 8'h8A)
				pc <= reg_wdata[2:0];
			if (reg_wr && reg_addr == 8'h8B)
				sup <= reg_wdata;
			if (line_valid)
				zrun <= line_bit ? 8'h00 : (zrun == 8'hFF ? zrun : zrun + 8'h01);
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	chk_spare_len: assert property (
		!e1_mode |=> spare_code_bits == {1'b0, $past(spare_code_length)} + 4'h1)
		else $error("spare length bits wrong");
	chk_port_off: assert property (!pc[0] |=> !test_port_clk_en)
		else $error("test port strobe while disabled");
	chk_port_rx: assert property (
		pc[0] && !pc[2] && rx_ok |=> test_port_clk_en && test_port_data == $past(rx_data))
		else $error("framer bit not passed to test port");
	chk_bit_drop: assert property (
		pc[0] && !chan_fbit && sup[chan_bit_index] |=> !test_port_clk_en)
		else $error("suppressed bit passed");
	chk_fbit_framed: assert property (
		pc[0] && chan_fbit && !(pc[1] && !e1_mode) |=> !test_port_clk_en)
		else $error("framing bit passed while framed");
	chk_los_run: assert property (signal_loss_cond == (zrun >= 8'hC0))
		else $error("loss of signal not at zero run 192");
	chk_t1_quiet: assert property (!e1_mode |-> !framing_event_pending)
		else $error("T1 framing events requested interrupt");
	chk_e1_request: assert property (
		e1_mode && $past(e1_mode) && $past(reg_rd && reg_addr == 8'h91)
		&& reg_rdata[3:0] != 4'h0 |-> framing_event_pending)
		else $error("E1 low flags raised no request");
	chk_alarm_rise: assert property (
		$rose(remote_alarm_cond) |-> ##[1:2] alarm_event_pending)
		else $error("alarm edge raised no request");
endmodule // rfs_assertions

bind rfs_top rfs_assertions u_chk (.clk_sys(clk_sys), .reset(reset), .e1_mode(e1_mode),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .line_valid(line_valid),
	.line_bit(line_bit), .remote_alarm_cond(remote_alarm_cond),
	.rx_data_valid(rx_data_valid), .rx_data(rx_data), .chan_bit_index(chan_bit_index),
	.chan_fbit(chan_fbit), .spare_code_length(spare_code_length),
	.spare_code_bits(spare_code_bits), .test_port_data(test_port_data),
	.test_port_clk_en(test_port_clk_en), .signal_loss_cond(signal_loss_cond),
	.alarm_event_pending(alarm_event_pending), .framing_event_pending(framing_event_pending));

// ### test/rfs_line_model.sv
`timescale 1ns/1ps
module rfs_line_model (
	input wire clk_sys,
	input wire reset,
	input wire send_zeros,
	output logic line_valid,
	output logic line_bit
);
	// ==========================================
	// One line bit every second cycle; between bits the data shows the inverse,
	// so a design that samples without the qualifier sees garbage
	always @(posedge clk_sys) begin
		if (reset) begin
			line_valid <= 1'h0;
			line_bit <= 1'h1;
		end else begin
			line_valid <= !line_valid;
			line_bit <= line_valid ? !line_bit : !send_zeros;
		end
	end
endmodule // rfs_line_model

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
	logic clk_sys = 1'h0;
	logic reset = 1'h1;
	logic e1_mode = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, zq = 1'h0, crc4_enable = 1'h0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, ts16_byte = 8'h00;
	logic [2:0] alm = 3'h0, chan_bit_index = 3'h0;
	logic [8:0] ev = 9'h000;
	logic [3:0] err = 4'h0;
	logic rx_data_valid = 1'h0, rx_data = 1'h0, tx_data_valid = 1'h0, tx_data = 1'h0;
	logic chan_fbit = 1'h0, mfs = 1'h0;
	wire [7:0] reg_rdata;
	wire [2:0] bus_device_position, spare_code_length;
	wire [3:0] spare_code_bits;
	wire line_valid, line_bit, interleave_enable, spare_code_long, test_port_data;
	wire test_port_clk_en, signal_loss_cond, alarm_event_pending, framing_event_pending;
	int bad_count = 0;
	int n_compared = 0;

	always #5 clk_sys = ~clk_sys;

	rfs_line_model line (.clk_sys(clk_sys), .reset(reset), .send_zeros(zq),
		.line_valid(line_valid), .line_bit(line_bit));

	// Short timer counts keep the free-running event checks brief
	rfs_top #(.MF_CYCLES(20), .ALIGN_CYCLES(10)) dut (.clk_sys(clk_sys), .reset(reset),
		.e1_mode(e1_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_valid(line_valid), .line_bit(line_bit),
		.remote_alarm_cond(alm[2]), .all_ones_alarm_cond(alm[1]), .frame_loss_cond(alm[0]),
		.pulse_density_violation(ev[0]), .b8zs_codeword(ev[1]), .resync_align_changed(ev[2]),
		.fbit_strobe(ev[3]), .fbit_error(err[0]), .fas_strobe(ev[4]), .fas_error(err[1]),
		.cas_strobe(ev[5]), .cas_error(err[2]), .crc_strobe(ev[6]), .crc_error(err[3]),
		.crc4_enable(crc4_enable), .crc_mf_boundary(ev[7]), .ts16_strobe(ev[8]),
		.ts16_mf_start(mfs), .ts16_byte(ts16_byte), .rx_data_valid(rx_data_valid),
		.rx_data(rx_data), .tx_data_valid(tx_data_valid), .tx_data(tx_data),
		.chan_bit_index(chan_bit_index), .chan_fbit(chan_fbit),
		.interleave_enable(interleave_enable), .bus_device_position(bus_device_position),
		.spare_code_length(spare_code_length), .spare_code_bits(spare_code_bits),
		.spare_code_long(spare_code_long), .test_port_data(test_port_data),
		.test_port_clk_en(test_port_clk_en), .signal_loss_cond(signal_loss_cond),
		.alarm_event_pending(alarm_event_pending),
		.framing_event_pending(framing_event_pending));

	// ==========================================
	// Bus and compare helpers
	task ck(input logic [7:0] got, input logic [7:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] msk, input logic [7:0] exp, input string m);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		#1 ck(reg_rdata & msk, exp, m);
	endtask
	task pe(input int i);
		@(posedge clk_sys);
		ev[i] <= 1'h1;
		@(posedge clk_sys);
		ev[i] <= 1'h0;
	endtask
	// Both streams carry opposite data, so the wrong source shows up at once
	task tp(input logic dir, input logic d, input logic [2:0] i, input logic f, input logic en);
		@(posedge clk_sys);
		rx_data_valid <= 1'h1;
		tx_data_valid <= 1'h1;
		rx_data <= d ^ dir;
		tx_data <= d ^ !dir;
		chan_bit_index <= i;
		chan_fbit <= f;
		@(posedge clk_sys);
		rx_data_valid <= 1'h0;
		tx_data_valid <= 1'h0;
		#1 ck({7'h00, test_port_clk_en}, {7'h00, en}, "port strobe");
		if (en)
			ck({7'h00, test_port_data}, {7'h00, d}, "port data");
	endtask

	// ==========================================
	// Scenarios
	task t_regs;
		logic [7:0] al [8] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h90, 8'h91, 8'h92, 8'hA0};
		wr(8'h92, 8'hFF);
		wr(8'hA0, 8'hFF);
		for (int c = 0; c < 8; c++)
			rd(al[c], 8'hFF, 8'h00, "reset or unmapped");
		wr(8'h88, 8'hFF);
		rd(8'h88, 8'hFF, 8'h7F, "ibus ctrl");
		ck({4'h0, interleave_enable, bus_device_position}, 8'h0F, "ibus on");
		wr(8'h88, 8'h05);
		#1 ck({4'h0, interleave_enable, bus_device_position}, 8'h05, "ibus off");
		for (int c = 0; c < 8; c++) begin
			wr(8'h89, 8'hF8 | c[7:0]);
			rd(8'h89, 8'hFF, c[7:0], "spare ctrl");
			ck({3'h0, spare_code_long, spare_code_bits}, {3'h0, c == 7, c[3:0] + 4'h1}, "spare");
		end
		e1_mode <= 1'h1;
		repeat (2) @(posedge clk_sys);
		#1 ck({3'h0, spare_code_long, spare_code_bits}, 8'h00, "spare in E1");
		e1_mode <= 1'h0;
		$display("t_regs done");
	endtask
	task t_port;
		wr(8'h8A, 8'hF9);
		rd(8'h8A, 8'hFF, 8'h01, "port ctrl");
		tp(0, 1, 3, 0, 1);
		tp(0, 0, 5, 0, 1);
		tp(0, 1, 0, 1, 0);
		wr(8'h8A, 8'h03);
		tp(0, 1, 0, 1, 1);
		e1_mode <= 1'h1;
		tp(0, 1, 0, 1, 0);
		e1_mode <= 1'h0;
		wr(8'h8A, 8'h05);
		tp(1, 1, 2, 0, 1);
		tp(1, 0, 2, 0, 1);
		wr(8'h8A, 8'h04);
		tp(1, 1, 2, 0, 0);
		wr(8'h8A, 8'h01);
		for (int c = 0; c < 8; c++) begin
			wr(8'h8B, 8'h01 << c);
			tp(0, 1, c[2:0], 0, 0);
			tp(0, 0, c[2:0] + 3'h1, 0, 1);
		end
		rd(8'h8B, 8'hFF, 8'h80, "suppress");
		$display("t_port done");
	endtask
	task t_alarm;
		logic [7:0] rb [3] = '{8'h01, 8'h04, 8'h08};
		for (int c = 0; c < 3; c++) begin
			alm[c] <= 1'h1;
			repeat (3) @(posedge clk_sys);
			#1 ck({7'h00, alarm_event_pending}, 8'h01, "pending");
			rd(8'h90, 8'hFF, rb[c], "rise");
			alm[c] <= 1'h0;
			repeat (3) @(posedge clk_sys);
			rd(8'h90, 8'hFF, rb[c] | (rb[c] << 4), "fall");
			wr(8'h90, rb[c]);
			rd(8'h90, 8'hFF, rb[c] << 4, "part clear");
			wr(8'h90, 8'hFF);
			rd(8'h90, 8'hFF, 8'h00, "clear");
		end
		$display("t_alarm done");
	endtask
	task t_los;
		int nz;
		nz = 0;
		zq <= 1'h1;
		for (int k = 0; k < 500 && nz < 192; k++) begin
			@(posedge clk_sys);
			if (line_valid && !line_bit)
				nz++;
			#1 ck({7'h00, signal_loss_cond}, {7'h00, nz >= 192}, "los");
		end
		rd(8'h90, 8'hFF, 8'h02, "los rise");
		rd(8'h91, 8'h18, 8'h18, "zero runs");
		zq <= 1'h0;
		repeat (6) @(posedge clk_sys);
		rd(8'h90, 8'hFF, 8'h22, "los fall");
		wr(8'h90, 8'hFF);
		wr(8'h91, 8'hFF);
		$display("t_los done");
	endtask
	task t_t1;
		pe(0);
		pe(1);
		pe(2);
		rd(8'h91, 8'hFF, 8'hA2, "T1 events");
		ck({7'h00, framing_event_pending}, 8'h00, "T1 no request");
		wr(8'h91, 8'hFF);
		err <= 4'h1;
		pe(3);
		rd(8'h91, 8'hFF, 8'h01, "fbit error");
		pe(3);
		rd(8'h91, 8'hFF, 8'h05, "severe framing");
		$display("t_t1 done");
	endtask
	task t_e1;
		e1_mode <= 1'h1;
		err <= 4'hE;
		wr(8'h91, 8'hFF);
		pe(4);
		pe(4);
		rd(8'h91, 8'h10, 8'h00, "fas two");
		pe(4);
		rd(8'h91, 8'h10, 8'h10, "fas three");
		pe(5);
		rd(8'h91, 8'h20, 8'h00, "cas one");
		pe(5);
		rd(8'h91, 8'h20, 8'h20, "cas two");
		repeat (16) pe(8);
		rd(8'h91, 8'h0C, 8'h04, "slot16 zeros");
		wr(8'h91, 8'h0C);
		ts16_byte <= 8'hFF;
		repeat (15) pe(8);
		rd(8'h91, 8'h0C, 8'h00, "slot16 15");
		pe(8);
		rd(8'h91, 8'h0C, 8'h08, "slot16 ones");
		ck({7'h00, framing_event_pending}, 8'h01, "E1 request");
		// A multiframe start mid-block must restart the 16-frame count
		ts16_byte <= 8'h00;
		wr(8'h91, 8'h0C);
		repeat (5) pe(8);
		mfs <= 1'h1;
		pe(8);
		mfs <= 1'h0;
		repeat (14) pe(8);
		rd(8'h91, 8'h04, 8'h00, "slot16 restart 15");
		pe(8);
		rd(8'h91, 8'h04, 8'h04, "slot16 restart 16");
		repeat (914) pe(6);
		rd(8'h91, 8'h40, 8'h00, "crc 914");
		pe(6);
		rd(8'h91, 8'h40, 8'h40, "crc 915");
		crc4_enable <= 1'h1;
		wr(8'h91, 8'hFF);
		repeat (30) @(posedge clk_sys);
		rd(8'h91, 8'h02, 8'h00, "no free mf");
		pe(7);
		rd(8'h91, 8'h02, 8'h02, "crc mf");
		crc4_enable <= 1'h0;
		wr(8'h91, 8'hFF);
		repeat (25) @(posedge clk_sys);
		rd(8'h91, 8'h03, 8'h03, "timed mf and align");
		$display("t_e1 done");
	endtask

	task results;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk_sys);
		reset <= 1'h0;
		t_regs;
		t_port;
		t_alarm;
		t_los;
		t_t1;
		t_e1;
		results;
	end

	// Whole run is near 2700 cycles; this leaves wide margin
	initial begin
		#200000;
		bad_count++;
		results;
	end
endmodule // tb
